// ---- verilog/ir_secondary_link_discovery.v ----
`timescale 1ns/10ps
`include "ir_secondary_link_defs.vh"

module ir_secondary_link_discovery #(
   parameter [31:0] IDLE_CYCLES = `IDLE_SECONDS * `CLOCK_HZ,
   parameter [15:0] TURN_CYCLES = `BIT_CLOCKS
)(
   input  wire       clock,
   input  wire       rst,
   input  wire       optical_receive_in,
   input  wire       ir_rx_valid,
   input  wire [7:0] ir_rx_data,
   input  wire       ir_rx_end,
   input  wire       ir_rx_busy,
   input  wire       ir_tx_ready,
   output reg        ir_tx_valid,
   output reg  [7:0] ir_tx_data,
   output reg        ir_tx_last,
   input  wire       host_rx_valid,
   input  wire [7:0] host_rx_data,
   output reg        host_cts_out,
   output reg        protocol_active_out,
   output reg        protocol_active_oe,
   output reg        osc_enable_out,
   output reg        connected_data_state,
   output reg        rx_overflow
);

   localparam [2:0] ST_POLL  = 3'b000;
   localparam [2:0] ST_TURN  = 3'b001;
   localparam [2:0] ST_SEND  = 3'b010;
   localparam [2:0] ST_CONN  = 3'b011;
   localparam [2:0] ST_SLEEP = 3'b100;

   reg  [2:0]  state;
   reg         opt_meta;
   reg         opt_sync;
   reg         opt_prev;
   reg  [7:0]  rx_mem [0:63];
   reg  [6:0]  rx_len;
   reg  [7:0]  host_buf [0:28];
   reg  [4:0]  wr_ptr;
   reg  [4:0]  rd_ptr;
   reg  [4:0]  host_count;
   reg  [31:0] idle_cnt;
   reg  [15:0] turn_cnt;
   reg  [7:0]  reply_kind;
   reg  [7:0]  tx_kind;
   reg  [5:0]  tx_idx;
   reg  [5:0]  tx_len;
   reg  [7:0]  tx_count;
   reg         pending_close;

   wire        rx_activity;
   wire        link_busy;
   wire        tx_fire;
   wire        tx_host_byte;
   wire        tx_is_last;
   wire        push;
   wire        pop;
   wire [4:0]  next_rd;
   wire [4:0]  next_wr;
   wire [5:0]  next_idx;
   wire [7:0]  frame_kind;
   wire [7:0]  frame_slot;
   wire        frame_ok;
   wire        idle_done;

   function [7:0] id_char;
      input [5:0] k;
      reg   [79:0] s;
      begin
         s = {`ID_NAME, `ID_REV};
         id_char = s[79 - 8 * k -: 8];
      end
   endfunction

   // Byte k of an outgoing frame
   function [7:0] tx_byte;
      input [7:0] kind;
      input [5:0] k;
      input [7:0] cnt;
      input [7:0] hbyte;
      begin
         if (k == 6'h00) begin
            tx_byte = kind;
         end else if (k == 6'h01) begin
            tx_byte = (kind == `KIND_DATA) ? cnt : `SLOT_ZERO;
         end else if (kind == `KIND_ID_REPLY) begin
            tx_byte = id_char(k - `TX_HDR_BYTES);
         end else begin
            tx_byte = hbyte;
         end
      end
   endfunction

   // Receive pulses on the optical line are low-going
   assign rx_activity  = ir_rx_valid | (opt_sync ^ opt_prev);
   assign link_busy    = ir_rx_busy | ~opt_sync | ir_rx_valid;
   assign tx_fire      = ir_tx_valid & ir_tx_ready;
   assign tx_host_byte = (tx_kind == `KIND_DATA) && (tx_idx >= `TX_HDR_BYTES);
   assign tx_is_last   = (tx_idx == tx_len - 6'h01);
   assign next_idx     = tx_idx + 6'h01;
   assign next_rd      = (rd_ptr == `HOST_LAST_IDX) ? 5'h00 : rd_ptr + 5'h01;
   assign next_wr      = (wr_ptr == `HOST_LAST_IDX) ? 5'h00 : wr_ptr + 5'h01;
   // Disconnected host bytes are dropped and never reach the link
   assign push = host_rx_valid && connected_data_state
                 && (host_count != `HOST_BLOCK_BYTES)
                 && (state != ST_SLEEP);
   assign pop        = tx_fire && tx_host_byte;
   assign frame_kind = rx_mem[0];
   assign frame_slot = rx_mem[1];
   // Runts below the header are dropped; the primary sends 6 or more
   assign frame_ok   = ir_rx_end && (rx_len >= `RX_MIN_HEADER);
   assign idle_done  = (idle_cnt >= IDLE_CYCLES - 32'h0000_0001);

   always @(posedge clock) begin
      if (rst) begin
         opt_meta <= 1'b1;
         opt_sync <= 1'b1;
         opt_prev <= 1'b1;
      end else begin
         opt_meta <= optical_receive_in;
         opt_sync <= opt_meta;
         opt_prev <= opt_sync;
      end
   end

   // Optical receive block; bytes past the block are lost and flagged
   always @(posedge clock) begin
      if (rst) begin
         rx_len      <= 7'h00;
         rx_overflow <= 1'b0;
      end else if (ir_rx_end || state == ST_SEND || state == ST_SLEEP) begin
         rx_len <= 7'h00;
      end else if (ir_rx_valid) begin
         if (rx_len != `RX_BLOCK_BYTES) begin
            rx_mem[rx_len[5:0]] <= ir_rx_data;
            rx_len              <= rx_len + 7'h01;
         end else begin
            rx_overflow <= 1'b1;
         end
      end
   end

   // Host block as a ring so pushes and pops can overlap
   always @(posedge clock) begin
      if (rst) begin
         wr_ptr     <= 5'h00;
         rd_ptr     <= 5'h00;
         host_count <= 5'h00;
      end else begin
         if (push) begin
            host_buf[wr_ptr] <= host_rx_data;
            wr_ptr           <= next_wr;
         end
         if (pop) begin
            rd_ptr <= next_rd;
         end
         if (push && !pop) begin
            host_count <= host_count + 5'h01;
         end else if (pop && !push) begin
            host_count <= host_count - 5'h01;
         end
      end
   end

   // Stop state is high; host overshoot up to the full block is absorbed
   always @(posedge clock) begin
      if (rst) begin
         host_cts_out <= 1'b1;
      end else begin
         host_cts_out <= !connected_data_state
                         || (host_count >= `HOST_CTS_LEVEL);
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         idle_cnt <= 32'h0000_0000;
      end else if (rx_activity || state == ST_SLEEP) begin
         idle_cnt <= 32'h0000_0000;
      end else if (!idle_done) begin
         idle_cnt <= idle_cnt + 32'h0000_0001;
      end
   end

   // Turnaround gap restarts on every sign of incoming traffic
   always @(posedge clock) begin
      if (rst) begin
         turn_cnt <= 16'h0000;
      end else if (link_busy) begin
         turn_cnt <= 16'h0000;
      end else if (turn_cnt != TURN_CYCLES) begin
         turn_cnt <= turn_cnt + 16'h0001;
      end
   end

   always @(posedge clock) begin
      if (rst) begin
         state                <= ST_POLL;
         connected_data_state <= 1'b0;
         pending_close        <= 1'b0;
         reply_kind           <= `KIND_ACK;
         tx_kind              <= `KIND_ACK;
         tx_idx               <= 6'h00;
         tx_len               <= `ACK_BYTES;
         tx_count             <= 8'h00;
         ir_tx_valid          <= 1'b0;
         ir_tx_data           <= 8'h00;
         ir_tx_last           <= 1'b0;
         protocol_active_out  <= 1'b0;
         protocol_active_oe   <= 1'b0;
         osc_enable_out       <= 1'b1;
      end else begin
         case (state)
            // Only reacts to the primary's frames, never polls itself
            ST_POLL: begin
               if (frame_ok && frame_kind == `KIND_DISCOVERY
                   && frame_slot == `SLOT_ZERO) begin
                  reply_kind <= `KIND_ID_REPLY;
                  state      <= ST_TURN;
               end else if (frame_ok && frame_kind == `KIND_CONNECT) begin
                  reply_kind           <= `KIND_ACK;
                  connected_data_state <= 1'b1;
                  state                <= ST_TURN;
               end else if (idle_done && !rx_activity) begin
                  // Later slots and the closing broadcast stay unanswered
                  osc_enable_out     <= 1'b0;
                  protocol_active_oe <= 1'b1;
                  state              <= ST_SLEEP;
               end
            end
            ST_CONN: begin
               if (frame_ok) begin
                  // Every poll gets a frame, even with nothing queued
                  if (frame_kind == `KIND_CLOSE) begin
                     reply_kind    <= `KIND_ACK;
                     pending_close <= 1'b1;
                  end else begin
                     reply_kind <= `KIND_DATA;
                  end
                  state <= ST_TURN;
               end else if (idle_done && !rx_activity) begin
                  connected_data_state <= 1'b0;
                  state                <= ST_POLL;
               end
            end
            ST_TURN: begin
               if (!link_busy && turn_cnt == TURN_CYCLES) begin
                  tx_kind     <= reply_kind;
                  tx_idx      <= 6'h00;
                  tx_count    <= {3'b000, host_count};
                  ir_tx_valid <= 1'b1;
                  ir_tx_last  <= 1'b0;
                  ir_tx_data  <= tx_byte(reply_kind, 6'h00, 8'h00, 8'h00);
                  state       <= ST_SEND;
                  if (reply_kind == `KIND_ID_REPLY) begin
                     tx_len <= `ID_REPLY_BYTES;
                  end else if (reply_kind == `KIND_DATA) begin
                     tx_len <= `TX_HDR_BYTES + {1'b0, host_count};
                  end else begin
                     tx_len <= `ACK_BYTES;
                  end
               end
            end
            ST_SEND: begin
               if (tx_fire) begin
                  if (tx_is_last) begin
                     ir_tx_valid <= 1'b0;
                     ir_tx_last  <= 1'b0;
                     if (pending_close || !connected_data_state) begin
                        pending_close        <= 1'b0;
                        connected_data_state <= 1'b0;
                        state                <= ST_POLL;
                     end else begin
                        state <= ST_CONN;
                     end
                  end else begin
                     tx_idx     <= next_idx;
                     ir_tx_last <= (next_idx == tx_len - 6'h01);
                     ir_tx_data <= tx_byte(tx_kind, next_idx, tx_count,
                        tx_host_byte ? host_buf[next_rd] : host_buf[rd_ptr]);
                  end
               end
            end
            ST_SLEEP: begin
               // Any optical edge brings the handler back
               if (rx_activity) begin
                  osc_enable_out     <= 1'b1;
                  protocol_active_oe <= 1'b0;
                  state              <= ST_POLL;
               end
            end
            default: begin
               state <= ST_POLL;
            end
         endcase
      end
   end

endmodule

// ---- verilog/ir_secondary_link_defs.vh ----
`ifndef IR_SECONDARY_LINK_DEFS_VH
`define IR_SECONDARY_LINK_DEFS_VH

// Device clock, link rate and idle timeout
`define CLOCK_HZ          32'h0773_5940
`define LINK_BAUD         32'h0000_2580
`define IDLE_SECONDS      32'h0000_000A
// One link bit time in device clocks, rounded up
`define BIT_CLOCKS        16'h32DD

// Optical receive block
`define RX_BLOCK_BYTES    7'h40
`define RX_MIN_HEADER     7'h02

// Host receive block
`define HOST_BLOCK_BYTES  5'h1D
`define HOST_LAST_IDX     5'h1C
`define HOST_CTS_LEVEL    5'h17

// Frame layout: kind byte, slot or length byte, then body
`define TX_HDR_BYTES      6'h02
`define ID_REPLY_BYTES    6'h0C
`define ACK_BYTES         6'h02
`define SLOT_ZERO         8'h00

// Frame kinds seen on the optical side
`define KIND_DISCOVERY    8'h01
`define KIND_BCAST_ID     8'h02
`define KIND_CONNECT      8'h03
`define KIND_DATA         8'h04
`define KIND_CLOSE        8'h05
`define KIND_ID_REPLY     8'h81
`define KIND_ACK          8'h83

// Fixed identifier, value arbitrary; last two characters are the revision
`define ID_NAME           64'h4952_5345_434C_4E4B
`define ID_REV            16'h4130

`endif

// ---- verif/link_checker_assertions.sv ----
`timescale 1ns/10ps
module link_checker #(
   parameter [31:0] IDLE_CYCLES = 32'h0000_07D0,
   parameter [15:0] TURN_CYCLES = 16'h0014
)(
   input wire       clock,
   input wire       rst,
   input wire       optical_receive_in,
   input wire       ir_rx_valid,
   input wire       ir_rx_end,
   input wire       ir_rx_busy,
   input wire       ir_tx_ready,
   input wire       ir_tx_valid,
   input wire [7:0] ir_tx_data,
   input wire       ir_tx_last,
   input wire       host_rx_valid,
   input wire       host_cts_out,
   input wire       protocol_active_out,
   input wire       protocol_active_oe,
   input wire       osc_enable_out,
   input wire       connected_data_state,
   input wire       rx_overflow
);
   reg [31:0] quiet;
   reg        owed;
   // Raw pin leads the design's synchroniser, so this count is never short
   always @(posedge clock) begin
      if (rst || ir_rx_busy || ir_rx_valid || !optical_receive_in)
         quiet <= 32'h0000_0000;
      else
         quiet <= quiet + 32'h0000_0001;
      if (rst || $rose(ir_tx_valid))
         owed <= 1'b0;
      else if (ir_rx_end)
         owed <= 1'b1;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   a_tx_holds: assert property (
      ir_tx_valid && !ir_tx_ready |=>
      ir_tx_valid && $stable(ir_tx_data) && $stable(ir_tx_last))
      else $error("reply byte changed before acceptance");
   a_reply_after_turn: assert property (
      $rose(ir_tx_valid) |-> owed && quiet >= {16'h0000, TURN_CYCLES})
      else $error("reply started early or unasked");
   a_frame_gap: assert property (
      ir_tx_valid && ir_tx_ready && ir_tx_last |=> !ir_tx_valid)
      else $error("no gap after last reply byte");
   a_cts_stop: assert property (
      !connected_data_state && !$past(connected_data_state) |->
      host_cts_out)
      else $error("host released while disconnected");
   a_cts_level: assert property (
      $rose(host_cts_out) && connected_data_state |->
      $past(host_rx_valid, 2) && $past(connected_data_state, 2))
      else $error("stop raised without a host byte");
   a_ovf_sticky: assert property (rx_overflow |=> rx_overflow)
      else $error("overflow flag cleared");
   a_ovf_cause: assert property (
      $rose(rx_overflow) |-> $past(ir_rx_valid))
      else $error("overflow without a received byte");
   a_sleep_pins: assert property (
      !protocol_active_out && protocol_active_oe == !osc_enable_out)
      else $error("sleep outputs disagree");
   a_sleep_idle: assert property (
      $rose(protocol_active_oe) |->
      quiet + 32'h0000_0002 >= IDLE_CYCLES && !$past(connected_data_state))
      else $error("slept too early");
   // Wake may come from a decoded byte or from a bare pulse on the pin
   a_wake_fast: assert property (
      protocol_active_oe && (ir_rx_valid || !optical_receive_in)
      |-> ##[1:3] !protocol_active_oe) else $error("no wake on activity");
endmodule

bind ir_secondary_link_discovery link_checker #(
   .IDLE_CYCLES(IDLE_CYCLES), .TURN_CYCLES(TURN_CYCLES)) chk (
   .clock(clock), .rst(rst), .optical_receive_in(optical_receive_in),
   .ir_rx_valid(ir_rx_valid), .ir_rx_end(ir_rx_end),
   .ir_rx_busy(ir_rx_busy), .ir_tx_ready(ir_tx_ready),
   .ir_tx_valid(ir_tx_valid), .ir_tx_data(ir_tx_data),
   .ir_tx_last(ir_tx_last), .host_rx_valid(host_rx_valid),
   .host_cts_out(host_cts_out), .protocol_active_out(protocol_active_out),
   .protocol_active_oe(protocol_active_oe),
   .osc_enable_out(osc_enable_out),
   .connected_data_state(connected_data_state), .rx_overflow(rx_overflow));

// ---- verif/primary_station.sv ----
`timescale 1ns/10ps
module primary_station (
   input  wire       clock,
   input  wire       slow,
   output reg        optical_receive_in,
   output reg        ir_rx_valid,
   output reg  [7:0] ir_rx_data,
   output reg        ir_rx_end,
   output reg        ir_rx_busy,
   output reg        ir_tx_ready,
   input  wire       ir_tx_valid,
   input  wire       ir_tx_last,
   input  wire [7:0] ir_tx_data
);
   reg [7:0] got [$];
   integer   last_sum = 0;
   initial begin
      optical_receive_in = 1'b1;
      ir_rx_valid = 1'b0;
      ir_rx_data = 8'h5A;
      ir_rx_end = 1'b0;
      ir_rx_busy = 1'b0;
      ir_tx_ready = 1'b0;
   end
   // Caller never asks for fewer than 6 bytes
   task send(input [7:0] kind, input [7:0] slot, input integer len);
      integer i;
      @(negedge clock);
      ir_rx_busy = 1'b1;
      for (i = 0; i < len; i = i + 1) begin
         ir_rx_valid = 1'b1;
         ir_rx_data = (i == 0) ? kind : (i == 1) ? slot : $urandom;
         @(negedge clock);
         ir_rx_valid = 1'b0;
         ir_rx_data = ~ir_rx_data;
         @(negedge clock);
      end
      ir_rx_busy = 1'b0;
      ir_rx_end = 1'b1;
      @(negedge clock);
      ir_rx_end = 1'b0;
   endtask
   always @(negedge clock)
      ir_tx_ready <= slow ? $urandom : 1'b1;
   // Positions flagged last add up to the frame length only when the
   // final byte alone carries the flag
   always @(posedge clock)
      if (ir_tx_valid && ir_tx_ready) begin
         if (ir_tx_last)
            last_sum <= last_sum + got.size() + 1;
         got.push_back(ir_tx_data);
      end
endmodule

// ---- verif/ir_secondary_link_discovery_tb.sv ----
`timescale 1ns/10ps
`include "ir_secondary_link_defs.vh"
module ir_secondary_link_discovery_tb;
   localparam [31:0] IDLE = 32'h0000_07D0;
   localparam [15:0] TURN = 16'h0014; // Short bit time
   reg        clock = 1'b0;
   reg        rst = 1'b1;
   reg        slow = 1'b0;
   reg        host_rx_valid = 1'b0;
   reg  [7:0] host_rx_data = 8'h00;
   wire       ir_rx_valid, ir_rx_end, ir_rx_busy, optical_receive_in;
   wire       ir_tx_ready, ir_tx_valid, ir_tx_last, host_cts_out;
   wire       protocol_active_out, protocol_active_oe, osc_enable_out;
   wire       connected_data_state, rx_overflow;
   wire [7:0] ir_rx_data, ir_tx_data;
   integer    err_count = 0;
   integer    compares = 0;
   integer    i;
   reg  [7:0] hq [$];
   reg  [7:0] exp [$];
   always #4 clock = ~clock;
   ir_secondary_link_discovery #(.IDLE_CYCLES(IDLE), .TURN_CYCLES(TURN)) dut (
      .clock(clock), .rst(rst), .optical_receive_in(optical_receive_in),
      .ir_rx_valid(ir_rx_valid), .ir_rx_data(ir_rx_data),
      .ir_rx_end(ir_rx_end), .ir_rx_busy(ir_rx_busy),
      .ir_tx_ready(ir_tx_ready), .ir_tx_valid(ir_tx_valid),
      .ir_tx_data(ir_tx_data), .ir_tx_last(ir_tx_last),
      .host_rx_valid(host_rx_valid), .host_rx_data(host_rx_data),
      .host_cts_out(host_cts_out), .protocol_active_out(protocol_active_out),
      .protocol_active_oe(protocol_active_oe),
      .osc_enable_out(osc_enable_out),
      .connected_data_state(connected_data_state), .rx_overflow(rx_overflow));
   primary_station peer (
      .clock(clock), .slow(slow), .optical_receive_in(optical_receive_in),
      .ir_rx_valid(ir_rx_valid), .ir_rx_data(ir_rx_data),
      .ir_rx_end(ir_rx_end), .ir_rx_busy(ir_rx_busy),
      .ir_tx_ready(ir_tx_ready), .ir_tx_valid(ir_tx_valid),
      .ir_tx_last(ir_tx_last), .ir_tx_data(ir_tx_data));
   function [7:0] id_byte(input integer k);
      reg [95:0] w;
      begin
         w = {`KIND_ID_REPLY, `SLOT_ZERO, `ID_NAME, `ID_REV};
         id_byte = w[95 - 8 * k -: 8];
      end
   endfunction
   task check(input [7:0] g, input [7:0] e);
      compares = compares + 1;
      if (g !== e) begin
         err_count = err_count + 1;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task stop_test;
      $display("compares=%0d errors=%0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Next frame only once the reply is over, keeping the link half duplex
   task xfer(input [7:0] kind, input [7:0] slot, input integer len);
      integer k;
      peer.got.delete();
      peer.last_sum = 0;
      peer.send(kind, slot, len);
      for (k = 0; k < 400; k = k + 1) begin
         @(negedge clock);
         if (exp.size() > 0 && peer.got.size() == exp.size() && !ir_tx_valid)
            k = 400;
      end
      repeat (4) @(negedge clock);
      check(peer.got.size(), exp.size());
      check(peer.last_sum, exp.size());
      for (k = 0; k < exp.size() && k < peer.got.size(); k = k + 1)
         check(peer.got[k], exp[k]);
      exp.delete();
   endtask
   task host(input integer n, input keep);
      integer k;
      for (k = 0; k < n; k = k + 1) begin
         host_rx_valid = 1'b1;
         host_rx_data = $urandom;
         if (keep && hq.size() < 29)
            hq.push_back(host_rx_data);
         @(negedge clock);
         host_rx_valid = 1'b0;
         @(negedge clock);
      end
   endtask
   task ack_next;
      exp.push_back(`KIND_ACK);
      exp.push_back(`SLOT_ZERO);
   endtask
   initial begin
      i = $urandom(32'h8aa6);
      repeat (12) @(negedge clock);
      rst = 1'b0;
      @(negedge clock);
      check({host_cts_out, osc_enable_out, protocol_active_oe,
             connected_data_state, rx_overflow, protocol_active_out}, 8'h30);
      host(4, 1'b0);
      check(host_cts_out, 1'b1);
      for (i = 0; i < 8; i = i + 1) begin
         slow = $urandom;
         if (i == 0)
            for (int k = 0; k < 12; k++) exp.push_back(id_byte(k));
         xfer(`KIND_DISCOVERY, i, 6 + $urandom % 4);
      end
      xfer(`KIND_BCAST_ID, $urandom, 6);
      ack_next;
      xfer(`KIND_CONNECT, 8'h00, 6);
      check({connected_data_state, host_cts_out}, 8'h02);
      host(22, 1'b1);
      check(host_cts_out, 1'b0);
      host(1, 1'b1);
      check(host_cts_out, 1'b1);
      host(7, 1'b1);
      slow = 1'b1;
      exp = {`KIND_DATA, 8'h1D, hq};
      xfer(`KIND_DATA, $urandom, 6);
      exp = {`KIND_DATA, 8'h00};
      xfer(`KIND_DATA, 8'h00, 64);
      check(rx_overflow, 1'b0);
      exp = {`KIND_DATA, 8'h00};
      xfer(`KIND_DATA, 8'h00, 65);
      check(rx_overflow, 1'b1);
      ack_next;
      xfer(`KIND_CLOSE, 8'h00, 6);
      check({connected_data_state, host_cts_out}, 8'h01);
      repeat (IDLE + 20) @(negedge clock);
      check({protocol_active_oe, osc_enable_out}, 8'h02);
      peer.optical_receive_in = 1'b0;
      @(negedge clock);
      peer.optical_receive_in = 1'b1;
      repeat (6) @(negedge clock);
      check({protocol_active_oe, osc_enable_out}, 8'h01);
      for (i = 0; i < 12; i = i + 1) exp.push_back(id_byte(i));
      xfer(`KIND_DISCOVERY, 8'h00, 6);
      // A connected link left silent falls back to polling, then sleeps
      ack_next;
      xfer(`KIND_CONNECT, 8'h00, 6);
      repeat (IDLE + 20) @(negedge clock);
      check({connected_data_state, protocol_active_oe,
             host_cts_out}, 8'h03);
      stop_test;
   end
   initial begin
      #200000;
      err_count = err_count + 1;
      stop_test;
   end
endmodule
